// ### hw/prc_pkg.sv
package prc_pkg;

  // bus widths
  localparam int unsigned AD_W     = 32;
  localparam int unsigned CBE_W    = 4;
  localparam int unsigned NUM_MSTR = 2;

  // clocking: logic is cycle based, so 25 MHz and 33 MHz both work
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned BUS_CLK_LOW_MHZ = 25;
  localparam int unsigned BUS_CLK_HI_MHZ  = 33;

  // re-park window after reset negation, in bus clocks
  localparam int unsigned PARK_MIN_CLKS = 2;
  localparam int unsigned PARK_MAX_CLKS = 5;

  // least reset pulse the reset source must give
  localparam int unsigned RESET_MIN_NS   = 1000;
  localparam int unsigned RESET_MIN_CLKS =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // release counter saturates here
  localparam logic [2:0] REL_CNT_MAX = 3'h7;

  // grant vector positions
  localparam int unsigned GNT_HOST = 0;
  localparam int unsigned GNT_M0   = 1;
  localparam int unsigned GNT_M1   = 2;
  localparam int unsigned GNT_W    = 3;

  // reset values
  localparam logic [AD_W-1:0]  AD_RST    = 32'h0000_0000;
  localparam logic [CBE_W-1:0] CBE_RST   = 4'h0;
  localparam logic [GNT_W-1:0] GNT_RST   = 3'h0;

  typedef enum logic [1:0] {
    PRC_ST_RESET = 2'b00,
    PRC_ST_STRAP = 2'b01,
    PRC_ST_RUN   = 2'b11
  } prc_state_type;

endpackage : prc_pkg

// ### hw/prc_reset_pins.sv
// Functional notes
// R1: all bus inputs sampled on rising clock
// R2: works at 25 MHz or 33 MHz
// R3: reset drives address/data, command, parity low
// R4: reset negation floats address/data, command, parity
// R5: host request level at release enables arbiter
// R6: arbiter enabled: re-park 2-5 clocks later
// R7: arbiter disabled: lines float until own use
// R8: reset floats control, request, grant outputs
// R9: control lines float until own transaction
// R10: request and grant outputs float until driven
// R11: requests go inactive at release, no clock
// R12: grants follow arbitration and asserted requests
// R13: reset returns every register to default
// R14: reset edges may be asynchronous to clock
// R15: reset source negates cleanly, without bounce
// R16: reset source holds reset over 1 us
// R17: release synchronised before counting and arbitration
`timescale 1ns/10ps
`default_nettype none

module prc_reset_pins #(
  parameter int unsigned AD_W     = prc_pkg::AD_W,
  parameter int unsigned CBE_W    = prc_pkg::CBE_W,
  parameter int unsigned NUM_MSTR = prc_pkg::NUM_MSTR
) (
  // clock and bus reset
  input  wire logic                i_clock,
  input  wire logic                i_rst_n,
  // bus state and requests
  input  wire logic                i_frame_n,
  input  wire logic                i_irdy_n,
  input  wire logic                i_host_bus_request_n,
  input  wire logic [NUM_MSTR-1:0] i_master_bus_requests_n,
  // own transaction engine
  input  wire logic                i_own_ad_oe,
  input  wire logic [AD_W-1:0]     i_own_ad,
  input  wire logic [CBE_W-1:0]    i_own_cbe_n,
  input  wire logic                i_own_par,
  input  wire logic                i_own_ctl_oe,
  input  wire logic                i_mem_req,
  input  wire logic                i_flush_req,
  input  wire logic                i_bridge_req,
  input  wire logic                i_resume,
  // address/data, command, parity pins
  output logic [AD_W-1:0]          o_ad,
  output logic [CBE_W-1:0]         o_cbe_n,
  output logic                     o_par,
  output logic                     o_ad_oe,
  // transaction control pins enable
  output logic                     o_ctl_oe,
  // sideband pins
  output logic                     o_memory_path_request_n,
  output logic                     o_memory_path_request_oe,
  output logic                     o_buffer_flush_request_n,
  output logic                     o_buffer_flush_request_oe,
  output logic                     o_host_bus_grant_n,
  output logic                     o_host_bus_grant_oe,
  output logic                     o_grant_zero_or_bridge_request_n,
  output logic                     o_grant_zero_or_bridge_request_oe,
  output logic                     o_grant_one_or_resume_n,
  output logic                     o_grant_one_or_resume_oe,
  // status
  output logic                     o_arbiter_enabled
);
  import prc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // reset release synchroniser
  logic rst_sync1_ff;
  logic rst_sync2_ff;
  // async assert, synchronous release; sync1 feeds sync2 only
  always_ff @(posedge i_clock or negedge i_rst_n) begin // R14
    if (!i_rst_n) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1; // R17
      rst_sync2_ff <= rst_sync1_ff; // R2
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // sequence state and strap capture
  prc_state_type state_ff;
  prc_state_type nxt_state;
  logic          arb_en_ff;
  logic          nxt_arb_en;
  always_comb begin
    nxt_state  = state_ff;
    nxt_arb_en = arb_en_ff;
    case (state_ff)
      PRC_ST_RESET: begin
        if (rst_sync2_ff) begin
          nxt_state = PRC_ST_STRAP;
        end
      end
      PRC_ST_STRAP: begin
        // strap held steady by the board around release
        nxt_arb_en = i_host_bus_request_n; // R5
        nxt_state  = PRC_ST_RUN;
      end
      PRC_ST_RUN: begin
        nxt_state = PRC_ST_RUN;
      end
      default: begin
        nxt_state = PRC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff  <= PRC_ST_RESET; // R13
      arb_en_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      arb_en_ff <= nxt_arb_en;
    end
  end

  logic running;
  assign running           = (state_ff == PRC_ST_RUN);
  assign o_arbiter_enabled = arb_en_ff;
  ////////////////////////////////////////////////////////////////////////////
  // arbiter: fixed priority host, master 0, master 1
  logic [GNT_W-1:0] gnt_ff;
  logic [GNT_W-1:0] nxt_gnt;
  logic [GNT_W-1:0] req;
  logic             bus_idle;
  assign bus_idle = i_frame_n && i_irdy_n; // R1
  assign req      = {~i_master_bus_requests_n[1],
                     ~i_master_bus_requests_n[0],
                     ~i_host_bus_request_n};
  always_comb begin
    nxt_gnt = gnt_ff;
    if (!running || !arb_en_ff) begin
      nxt_gnt = GNT_RST;
    end else if (bus_idle) begin // R12
      // re-arbitrate only on an idle bus so a transfer is never cut
      if (req[GNT_HOST]) begin
        nxt_gnt = 3'h1;
      end else if (req[GNT_M0]) begin
        nxt_gnt = 3'h2;
      end else if (req[GNT_M1]) begin
        nxt_gnt = 3'h4;
      end else begin
        nxt_gnt = GNT_RST;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gnt_ff <= GNT_RST; // R13
    end else begin
      gnt_ff <= nxt_gnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // sideband request and multiplexed pins
  logic mem_req_ff;
  logic nxt_mem_req;
  logic flush_req_ff;
  logic nxt_flush_req;
  logic mux0_ff;
  logic nxt_mux0;
  logic mux1_ff;
  logic nxt_mux1;
  always_comb begin
    nxt_mem_req   = i_mem_req;
    nxt_flush_req = i_flush_req;
    // arbiter off: pins carry bridge request and resume instead
    nxt_mux0 = arb_en_ff ? nxt_gnt[GNT_M0] : i_bridge_req;
    nxt_mux1 = arb_en_ff ? nxt_gnt[GNT_M1] : i_resume;
    if (!running) begin
      nxt_mux0 = 1'b0;
      nxt_mux1 = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_req_ff   <= 1'b0; // R13
      flush_req_ff <= 1'b0;
      mux0_ff      <= 1'b0;
      mux1_ff      <= 1'b0;
    end else begin
      mem_req_ff   <= nxt_mem_req;
      flush_req_ff <= nxt_flush_req;
      mux0_ff      <= nxt_mux0;
      mux1_ff      <= nxt_mux1;
    end
  end

  // enable follows the reset pin itself: inactive level with no clock
  assign o_memory_path_request_oe  = i_rst_n; // R8 R11
  assign o_buffer_flush_request_oe = i_rst_n; // R8 R11
  assign o_memory_path_request_n   = ~mem_req_ff; // R11
  assign o_buffer_flush_request_n  = ~flush_req_ff; // R11

  assign o_host_bus_grant_oe = i_rst_n && running && arb_en_ff; // R10
  assign o_host_bus_grant_n  = ~gnt_ff[GNT_HOST]; // R12
  assign o_grant_zero_or_bridge_request_oe = i_rst_n && running; // R10
  assign o_grant_zero_or_bridge_request_n  = ~mux0_ff;
  assign o_grant_one_or_resume_oe = i_rst_n && running; // R10
  assign o_grant_one_or_resume_n  = ~mux1_ff;
  assign o_ctl_oe = i_rst_n && i_own_ctl_oe; // R8 R9
  ////////////////////////////////////////////////////////////////////////////
  // address/data, command, parity drive and parking
  logic [AD_W-1:0]  ad_ff;
  logic [AD_W-1:0]  nxt_ad;
  logic [CBE_W-1:0] cbe_ff;
  logic [CBE_W-1:0] nxt_cbe;
  logic             par_ff;
  logic             nxt_par;
  logic             ad_oe_ff;
  logic             nxt_ad_oe;
  logic             park;
  // central resource parks only with no grant out and an idle bus
  assign park = running && arb_en_ff && (gnt_ff == GNT_RST) && bus_idle;
  always_comb begin
    nxt_ad    = AD_RST;
    nxt_cbe   = CBE_RST;
    nxt_par   = 1'b0;
    nxt_ad_oe = 1'b0;
    if (i_own_ad_oe) begin // R7
      nxt_ad    = i_own_ad;
      nxt_cbe   = i_own_cbe_n;
      nxt_par   = i_own_par;
      nxt_ad_oe = 1'b1;
    end else if (park) begin // R6
      nxt_ad_oe = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ad_ff    <= AD_RST; // R3
      cbe_ff   <= CBE_RST;
      par_ff   <= 1'b0;
      ad_oe_ff <= 1'b0; // R4
    end else begin
      ad_ff    <= nxt_ad;
      cbe_ff   <= nxt_cbe;
      par_ff   <= nxt_par;
      ad_oe_ff <= nxt_ad_oe;
    end
  end

  assign o_ad    = ad_ff;
  assign o_cbe_n = cbe_ff;
  assign o_par   = par_ff;
  // low drive from reset assertion, released the moment reset lifts
  assign o_ad_oe = !i_rst_n || ad_oe_ff; // R3 R4
  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [2:0] rel_cnt_ff;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rel_cnt_ff <= 3'h0;
    end else if (rel_cnt_ff != REL_CNT_MAX) begin
      rel_cnt_ff <= rel_cnt_ff + 3'h1;
    end
  end
  // park enable registers at the fifth edge, seen one edge later
  property p_park_window;
    @(posedge i_clock) disable iff (!i_rst_n)
    (rel_cnt_ff == 3'h4) && arb_en_ff && bus_idle && (req == 3'h0)
      |=> o_ad_oe;
  endproperty
  a_park_window: assert property (p_park_window) // R6
    else $error("bus not parked by fifth clock after release");
  property p_no_early_park;
    @(posedge i_clock) disable iff (!i_rst_n)
    (rel_cnt_ff < 3'h2) && !$past(i_own_ad_oe) |-> !o_ad_oe;
  endproperty
  a_no_early_park: assert property (p_no_early_park) // R4
    else $error("address lines driven right after release");
  property p_disabled_float;
    @(posedge i_clock) disable iff (!i_rst_n)
    running && !arb_en_ff && !i_own_ad_oe |=> !o_ad_oe;
  endproperty
  a_disabled_float: assert property (p_disabled_float) // R7
    else $error("address lines driven with arbiter disabled");
  property p_strap;
    @(posedge i_clock) disable iff (!i_rst_n)
    (state_ff == PRC_ST_STRAP) |=> arb_en_ff == $past(i_host_bus_request_n);
  endproperty
  a_strap: assert property (p_strap) // R5
    else $error("arbiter enable not taken from host request");
  property p_sync_order;
    @(posedge i_clock) disable iff (!i_rst_n)
    $rose(rst_sync2_ff) |-> ##1 (state_ff == PRC_ST_STRAP) ##1 running;
  endproperty
  a_sync_order: assert property (p_sync_order) // R17
    else $error("sequence did not follow synchronised release");
  property p_grant_float;
    @(posedge i_clock) disable iff (!i_rst_n)
    !running |-> !o_host_bus_grant_oe && !o_grant_one_or_resume_oe
      && !o_grant_zero_or_bridge_request_oe && (gnt_ff == GNT_RST);
  endproperty
  a_grant_float: assert property (p_grant_float) // R10
    else $error("grant driven before sequence done");
  property p_host_grant;
    @(posedge i_clock) disable iff (!i_rst_n)
    running && arb_en_ff && bus_idle && !i_host_bus_request_n
      |=> !o_host_bus_grant_n;
  endproperty
  a_host_grant: assert property (p_host_grant) // R12
    else $error("host request on idle bus not granted");
  property p_grant_onehot;
    @(posedge i_clock) disable iff (!i_rst_n)
    $onehot0(gnt_ff) && (arb_en_ff || (gnt_ff == GNT_RST));
  endproperty
  a_grant_onehot: assert property (p_grant_onehot) // R12
    else $error("more than one grant or grant with arbiter off");
  property p_req_inactive;
    @(posedge i_clock) disable iff (!i_rst_n)
    !i_mem_req && !i_flush_req |=> o_memory_path_request_n
      && o_buffer_flush_request_n && o_memory_path_request_oe;
  endproperty
  a_req_inactive: assert property (p_req_inactive) // R11
    else $error("request outputs not inactive");
  property p_ctl_float;
    @(posedge i_clock) disable iff (!i_rst_n)
    !i_own_ctl_oe |-> !o_ctl_oe;
  endproperty
  a_ctl_float: assert property (p_ctl_float) // R9
    else $error("control lines driven without own transaction");
  c_park: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    arb_en_ff && $rose(ad_oe_ff));
  c_disabled: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    running && !arb_en_ff);
  c_m1_grant: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    gnt_ff[GNT_M1]);
endmodule : prc_reset_pins

`default_nettype wire

// ### verif/pci_reset_pin_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module pci_reset_pin_control_tb_top;
  import prc_pkg::*;
  logic                clock;
  logic                rst_n, frame_n, irdy_n, host_req_n;
  logic [NUM_MSTR-1:0] mreq_n;
  logic                own_ad_oe, own_par, own_ctl_oe;
  logic [AD_W-1:0]     own_ad, ad;
  logic [CBE_W-1:0]    own_cbe_n, cbe_n;
  logic                mem_req, flush_req, bridge_req, resume;
  logic                par, ad_oe, ctl_oe, mp_n, mp_oe, fl_n, fl_oe;
  logic                hg_n, hg_oe, g0_n, g0_oe, g1_n, g1_oe, arb_en;
  int                  err_total;
  int                  cmp_count;

  initial clock = 1'b0;
  always #(CLK_PERIOD_NS / 2) clock = ~clock;

  prc_bus_agent agent (
    .i_clock                 (clock),
    .o_rst_n                 (rst_n),
    .o_frame_n               (frame_n),
    .o_irdy_n                (irdy_n),
    .o_host_bus_request_n    (host_req_n),
    .o_master_bus_requests_n (mreq_n)
  );

  prc_reset_pins dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_frame_n(frame_n),
    .i_irdy_n(irdy_n), .i_host_bus_request_n(host_req_n),
    .i_master_bus_requests_n(mreq_n), .i_own_ad_oe(own_ad_oe),
    .i_own_ad(own_ad), .i_own_cbe_n(own_cbe_n), .i_own_par(own_par),
    .i_own_ctl_oe(own_ctl_oe), .i_mem_req(mem_req),
    .i_flush_req(flush_req), .i_bridge_req(bridge_req),
    .i_resume(resume), .o_ad(ad), .o_cbe_n(cbe_n), .o_par(par),
    .o_ad_oe(ad_oe), .o_ctl_oe(ctl_oe),
    .o_memory_path_request_n(mp_n), .o_memory_path_request_oe(mp_oe),
    .o_buffer_flush_request_n(fl_n), .o_buffer_flush_request_oe(fl_oe),
    .o_host_bus_grant_n(hg_n), .o_host_bus_grant_oe(hg_oe),
    .o_grant_zero_or_bridge_request_n(g0_n),
    .o_grant_zero_or_bridge_request_oe(g0_oe),
    .o_grant_one_or_resume_n(g1_n), .o_grant_one_or_resume_oe(g1_oe),
    .o_arbiter_enabled(arb_en)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // bounded wait for the park drive
  task automatic wait_oe(input int lim);
    int k;
    for (k = 0; k < lim && ad_oe !== 1'b1; k++) tick(1);
    if (ad_oe !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: park timeout seen %h expected 1", $time,
               ad_oe);
      summarize();
    end
  endtask : wait_oe

  ////////////////////////////////////////////////////////////////////////
  // own drive held high so a leak past reset shows on the lines
  task automatic do_reset(input logic strap);
    own_ad_oe  = 1'b1;
    own_ad     = 32'hFFFF_FFFF;
    own_ctl_oe = 1'b1;
    agent.assert_reset(strap);
    #1;
    chk({ad_oe, ad, cbe_n, par}, {1'b1, AD_RST, CBE_RST, 1'b0});
    chk({ctl_oe, mp_oe, fl_oe, hg_oe, g0_oe, g1_oe}, 6'h00);
    tick(3);
    chk({ad_oe, ad, cbe_n, par}, {1'b1, AD_RST, CBE_RST, 1'b0});
    chk({ctl_oe, g0_oe, g1_oe, arb_en}, 4'h0);
    own_ad_oe  = 1'b0;
    own_ctl_oe = 1'b0;
    agent.release_reset();
    #1;
    chk({ad_oe, mp_oe, mp_n, fl_oe, fl_n}, 5'h0f);
    tick(1);
    chk(ad_oe, 1'b0);
    if (strap) begin
      wait_oe(PARK_MAX_CLKS - 1);
    end else begin
      tick(PARK_MAX_CLKS + 3);
      chk(ad_oe, 1'b0);
    end
    chk({arb_en, hg_oe, g0_oe, g1_oe}, {strap, strap, 2'h3});
  endtask : do_reset

  task automatic t_arbitrate();
    agent.set_bus(1'b0, 1'b0, 2'h3);
    tick(1);
    chk({hg_n, g0_n, g1_n}, 3'h3);
    tick(1);
    chk(ad_oe, 1'b0);
    // busy bus must freeze the grant
    agent.set_bus(1'b1, 1'b1, 2'h0);
    tick(2);
    chk({hg_n, g0_n, g1_n}, 3'h3);
    agent.set_bus(1'b0, 1'b1, 2'h0);
    tick(1);
    chk({hg_n, g0_n, g1_n}, 3'h5);
    agent.set_bus(1'b0, 1'b1, 2'h1);
    tick(1);
    chk({hg_n, g0_n, g1_n}, 3'h6);
    agent.set_bus(1'b0, 1'b1, 2'h3);
    tick(1);
    chk({hg_n, g0_n, g1_n}, 3'h7);
    wait_oe(3);
  endtask : t_arbitrate

  task automatic t_own();
    own_ad_oe  = 1'b1;
    own_ad     = 32'hA5A5_5A5A;
    own_cbe_n  = 4'h3;
    own_par    = 1'b1;
    own_ctl_oe = 1'b1;
    mem_req    = 1'b1;
    flush_req  = 1'b1;
    bridge_req = 1'b1;
    resume     = 1'b1;
    #1;
    chk(ctl_oe, 1'b1);
    tick(1);
    chk({ad_oe, ad, cbe_n, par}, {1'b1, 32'hA5A5_5A5A, 4'h3, 1'b1});
    chk({mp_n, fl_n, g0_n, g1_n}, 4'h0);
    own_ad_oe  = 1'b0;
    own_ctl_oe = 1'b0;
    mem_req    = 1'b0;
    flush_req  = 1'b0;
    bridge_req = 1'b0;
    resume     = 1'b0;
    tick(1);
    chk({ad_oe, ctl_oe, mp_n, fl_n, g0_n, g1_n}, 6'h0f);
  endtask : t_own

  ////////////////////////////////////////////////////////////////////////
  initial begin
    err_total  = 0;
    cmp_count  = 0;
    own_ad_oe  = 1'b0;
    own_ad     = 32'h0000_0000;
    own_cbe_n  = 4'hF;
    own_par    = 1'b0;
    own_ctl_oe = 1'b0;
    mem_req    = 1'b0;
    flush_req  = 1'b0;
    bridge_req = 1'b0;
    resume     = 1'b0;
    do_reset(1'b1);
    t_arbitrate();
    do_reset(1'b0);
    t_own();
    summarize();
  end

endmodule : pci_reset_pin_control_tb_top
`default_nettype wire

// ### verif/prc_bus_agent.sv
`timescale 1ns/10ps
`default_nettype none

module prc_bus_agent (
  // clock
  input  wire logic                       i_clock,
  // reset source and bus agents
  output logic                            o_rst_n,
  output logic                            o_frame_n,
  output logic                            o_irdy_n,
  output logic                            o_host_bus_request_n,
  output logic [prc_pkg::NUM_MSTR-1:0]    o_master_bus_requests_n
);
  import prc_pkg::*;
  time t_assert;

  // starts released so the first reset gives a real falling edge
  initial begin
    o_rst_n                 = 1'b1;
    o_frame_n               = 1'b1;
    o_irdy_n                = 1'b1;
    o_host_bus_request_n    = 1'b1;
    o_master_bus_requests_n = 2'h3;
    t_assert                = 0;
  end

  // off the clock edge on purpose: the bridge must not rely on alignment
  task automatic assert_reset(input logic strap);
    #2;
    o_rst_n                 = 1'b0;
    o_host_bus_request_n    = strap;
    o_master_bus_requests_n = 2'h3;
    t_assert                = $time;
  endtask : assert_reset

  task automatic release_reset();
    while ($time - t_assert <= RESET_MIN_NS) @(posedge i_clock);
    #3;
    o_rst_n = 1'b1;
  endtask : release_reset

  // called just after a rising edge; frame/irdy idle high on pull-ups
  task automatic set_bus(input logic busy, input logic host_n,
                         input logic [NUM_MSTR-1:0] mreq_n);
    o_frame_n               = ~busy;
    o_irdy_n                = ~busy;
    o_host_bus_request_n    = host_n;
    o_master_bus_requests_n = mreq_n;
  endtask : set_bus

endmodule : prc_bus_agent
`default_nettype wire
